// [sec_pkg.sv]
// Constants, types and check-code helpers for the SRAM ECC wrapper.
// Assumes a single AHB-Lite slave port and one clock domain.
`default_nettype none

package sec_pkg;

   // Storage: 48KB main plus 4KB shared, one 39-bit entry per word
   localparam int          SEC_DATA_W     = 32;
   localparam int          SEC_CODE_W     = 7;
   localparam int          SEC_SYN_W      = 6;
   localparam int          SEC_WORD_W     = SEC_DATA_W + SEC_CODE_W;
   localparam int          SEC_MAIN_BYTES = 49152;
   localparam int          SEC_SHRD_BYTES = 4096;
   localparam int          SEC_DEPTH      = (SEC_MAIN_BYTES + SEC_SHRD_BYTES) / 4;
   localparam int          SEC_IDX_W      = 14;
   localparam int          SEC_CODE_POS   = 38;

   // Address windows; both aliases reach the same array
   localparam logic [15:0] SEC_WIN_PRI    = 16'h2000;
   localparam logic [15:0] SEC_WIN_ALT    = 16'h0A00;
   localparam logic [15:0] SEC_WIN_LIMIT  = 16'hD000;

   // Control and status registers
   localparam logic [31:0] SEC_REG_STATUS = 32'h5000_0000;
   localparam logic [31:0] SEC_REG_ENABLE = 32'h5000_0004;
   localparam logic [31:0] SEC_REG_ERRADR = 32'h5000_0008;
   localparam int          SEC_BIT_SINGLE = 0;
   localparam int          SEC_BIT_DOUBLE = 1;
   localparam logic [1:0]  SEC_RST_FLAGS  = 2'h0;
   localparam logic [1:0]  SEC_RST_ENABLE = 2'h0;
   localparam logic [31:0] SEC_RST_ERRADR = 32'h0000_0000;

   // AHB encodings
   localparam logic [2:0]  SEC_SIZE_BYTE  = 3'h0;
   localparam logic [2:0]  SEC_SIZE_HALF  = 3'h1;
   localparam logic [2:0]  SEC_SIZE_WORD  = 3'h2;

   typedef struct packed {
      logic [31:0]          addr;
      logic                 write;
      logic [2:0]           size;
      logic                 mem_hit;
      logic                 reg_hit;
   } sec_req_t;

   typedef struct packed {
      logic                 single_err;
      logic                 double_err;
      logic [31:0]          data;
   } sec_dec_t;

   // Hamming check bits over positions 1..38 plus overall parity
   function automatic logic [SEC_CODE_W-1:0] sec_encode(
         input logic [SEC_DATA_W-1:0] d);
      logic [SEC_SYN_W-1:0] c;
      int                   k;
      c = '0;
      k = 0;
      for (int p = 1; p <= SEC_CODE_POS; p++) begin
         if ((p & (p - 1)) != 0) begin
            for (int i = 0; i < SEC_SYN_W; i++) begin
               if (p[i]) begin
                  c[i] = c[i] ^ d[k];
               end
            end
            k++;
         end
      end
      return {^{d, c}, c};
   endfunction

   // Data bit that sits at the syndrome's position, if any
   function automatic logic [SEC_DATA_W-1:0] sec_flip(
         input logic [SEC_SYN_W-1:0] syn);
      logic [SEC_DATA_W-1:0] m;
      int                    k;
      m = '0;
      k = 0;
      for (int p = 1; p <= SEC_CODE_POS; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (SEC_SYN_W'(p) == syn) begin
               m[k] = 1'b1;
            end
            k++;
         end
      end
      return m;
   endfunction

endpackage
`default_nettype wire

// [sec_mem.sv]
// Single-port storage for data and check code, registered read data.
// Assumes one access per cycle; write and read never share a cycle.
`timescale 1ns/1ns
`default_nettype none

module sec_mem
   import sec_pkg::*;
(
   input  wire logic                  CLK,
   input  wire logic                  RST,
   input  wire logic                  en,
   input  wire logic                  we,
   input  wire logic [SEC_IDX_W-1:0]  addr,
   input  wire logic [SEC_WORD_W-1:0] wdata,
   output var  logic [SEC_WORD_W-1:0] rdata_q
);
   // No reset on the array: contents are unknown until written
   logic [SEC_WORD_W-1:0] mem [SEC_DEPTH];

   always_ff @(posedge CLK) begin
      if (en && we) begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rdata_q <= '0;
      end else if (en && !we) begin
         rdata_q <= mem[addr];
      end
   end

endmodule // sec_mem
`default_nettype wire

// [sec_ctrl.sv]
// SRAM ECC wrapper: AHB-Lite slave, encoder, decoder, error reporting.
// Assumes a single AHB-Lite master; HREADY is this slave's HREADYOUT.
// Function
// - Byte, half-word and word accesses reach 48KB at the base.
// - Each word carries a 7-bit SEC-DED check code.
// - Writes store a freshly computed code next to the data.
// - Reads recompute the code, give status and failing bit; the code corrects that bit but reports no bit position.
// - Narrow reads fetch and check the whole containing word.
// - Narrow writes are read, merged and written back whole.
// - Single error sets a sticky flag; software writes one to clear.
// - Single error captures the access address.
// - Double error sets a sticky flag; software writes one to clear.
// - Double error captures the access address.
// - Enabled single error raises the normal interrupt.
// - Enabled double error raises the non-maskable interrupt.
// - Two address windows reach the same main array.
// - Shared 4KB region reachable through both windows.
// - Control unit holds error flags and interrupt enables.
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module sec_ctrl
   import sec_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic             HREADYOUT,
   output logic [31:0]      HRDATA,
   output logic             HRESP,
   output logic             IRQ,
   output logic             NMI
);

   typedef enum logic [3:0] {
      ST_IDLE, ST_RD_ISSUE, ST_RD_CHECK, ST_WR_WORD, ST_RMW_ISSUE,
      ST_RMW_MERGE, ST_REG_RD, ST_REG_WR, ST_RESP
   } sec_state_t;

   sec_state_t            state_q;
   sec_state_t            state_d;
   sec_req_t              req_q;
   sec_req_t              req_d;
   sec_dec_t              dec;
   logic                  accept;
   logic                  win_hit;
   logic [15:0]           win_off;
   logic [31:0]           rdata_q;
   logic [1:0]            flags_q;
   logic [1:0]            enable_q;
   logic [31:0]           err_addr_q;
   logic                  mem_en;
   logic                  mem_we;
   logic [SEC_IDX_W-1:0]  mem_addr;
   logic [SEC_WORD_W-1:0] mem_wdata;
   logic [SEC_WORD_W-1:0] mem_rdata;
   logic [SEC_SYN_W-1:0]  syn;
   logic                  par_bad;
   logic                  chk_valid;
   logic                  single_ev;
   logic                  double_ev;
   logic [3:0]            lanes;
   logic [31:0]           merged;
   logic                  clr_single;
   logic                  clr_double;

   // Shared region follows main array in both windows
   always_comb begin
      win_off = HADDR[15:0];
      win_hit = (HADDR[31:16] == SEC_WIN_PRI || HADDR[31:16] == SEC_WIN_ALT)
                && (win_off < SEC_WIN_LIMIT);
   end

   assign accept = HSEL && HREADY && HTRANS[1];

   always_comb begin
      req_d.addr    = HADDR;
      req_d.write   = HWRITE;
      req_d.size    = HSIZE;
      req_d.mem_hit = win_hit;
      req_d.reg_hit = !win_hit;
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         req_q <= '0;
      end else if (accept) begin
         req_q <= req_d;
      end
   end

   // Ready only in states where no access is still outstanding
   always_comb begin
      unique case (state_q)
         ST_IDLE, ST_WR_WORD, ST_RMW_MERGE, ST_REG_WR, ST_RESP:
            HREADYOUT = 1'b1;
         default:
            HREADYOUT = 1'b0;
      endcase
   end

   // Narrow reads take the full-word path
   // Narrow writes take the read-modify-write path
   always_comb begin
      state_d = state_q;
      if (HREADYOUT) begin
         state_d = ST_IDLE;
         if (accept) begin
            if (!win_hit) begin
               state_d = HWRITE ? ST_REG_WR : ST_REG_RD;
            end else if (!HWRITE) begin
               state_d = ST_RD_ISSUE;
            end else if (HSIZE == SEC_SIZE_WORD) begin
               state_d = ST_WR_WORD;
            end else begin
               state_d = ST_RMW_ISSUE;
            end
         end
      end else begin
         unique case (state_q)
            ST_RD_ISSUE:  state_d = ST_RD_CHECK;
            ST_RD_CHECK:  state_d = ST_RESP;
            ST_RMW_ISSUE: state_d = ST_RMW_MERGE;
            ST_REG_RD:    state_d = ST_RESP;
            default:      state_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Byte lanes for byte, half-word and word writes
   always_comb begin
      unique case (req_q.size)
         SEC_SIZE_BYTE: lanes = 4'h1 << req_q.addr[1:0];
         SEC_SIZE_HALF: lanes = req_q.addr[1] ? 4'hC : 4'h3;
         default:       lanes = 4'hF;
      endcase
   end

   // Syndrome and overall parity from the stored word
   always_comb begin
      syn     = mem_rdata[SEC_DATA_W +: SEC_SYN_W]
                ^ SEC_SYN_W'(sec_encode(mem_rdata[SEC_DATA_W-1:0]));
      par_bad = ^mem_rdata;
   end

   // Single error when parity fails, double when only syndrome
   // Corrected word has the failing bit inverted
   always_comb begin
      dec.single_err = par_bad;
      dec.double_err = !par_bad && (syn != '0);
      dec.data       = mem_rdata[SEC_DATA_W-1:0]
                       ^ (par_bad ? sec_flip(syn) : '0);
   end

   // Merged bytes start from corrected data so a single error heals
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         merged[8*b +: 8] = lanes[b] ? HWDATA[8*b +: 8] : dec.data[8*b +: 8];
      end
   end

   always_comb begin
      mem_en    = 1'b0;
      mem_we    = 1'b0;
      mem_addr  = req_q.addr[2 +: SEC_IDX_W];
      mem_wdata = {sec_encode(HWDATA), HWDATA};
      unique case (state_q)
         ST_RD_ISSUE, ST_RMW_ISSUE: begin
            mem_en = 1'b1;
         end
         ST_WR_WORD: begin
            mem_en = 1'b1;
            mem_we = 1'b1;
         end
         ST_RMW_MERGE: begin
            mem_en    = 1'b1;
            mem_we    = 1'b1;
            mem_wdata = {sec_encode(merged), merged};
         end
         default: begin
            mem_en = 1'b0;
         end
      endcase
   end

   sec_mem u_mem (
      .CLK     (CLK),
      .RST     (RST),
      .en      (mem_en),
      .we      (mem_we),
      .addr    (mem_addr),
      .wdata   (mem_wdata),
      .rdata_q (mem_rdata)
   );

   assign chk_valid = (state_q == ST_RD_CHECK) || (state_q == ST_RMW_MERGE);
   assign single_ev = chk_valid && dec.single_err;
   assign double_ev = chk_valid && dec.double_err;

   // Read data comes from a flop; unmapped reads return zero
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rdata_q <= '0;
      end else if (state_q == ST_RD_CHECK) begin
         rdata_q <= dec.data;
      end else if (state_q == ST_REG_RD) begin
         unique case (req_q.addr)
            SEC_REG_STATUS: rdata_q <= {30'h0, flags_q};
            SEC_REG_ENABLE: rdata_q <= {30'h0, enable_q};
            SEC_REG_ERRADR: rdata_q <= err_addr_q;
            default:        rdata_q <= '0;
         endcase
      end
   end

   assign HRDATA = rdata_q;
   assign HRESP  = 1'b0;

   always_comb begin
      clr_single = (state_q == ST_REG_WR) && (req_q.addr == SEC_REG_STATUS)
                   && HWDATA[SEC_BIT_SINGLE];
      clr_double = (state_q == ST_REG_WR) && (req_q.addr == SEC_REG_STATUS)
                   && HWDATA[SEC_BIT_DOUBLE];
   end

   // Sticky single flag, set beats clear
   // Sticky double flag, set beats clear
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         flags_q <= SEC_RST_FLAGS;
      end else begin
         if (single_ev) begin
            flags_q[SEC_BIT_SINGLE] <= 1'b1;
         end else if (clr_single) begin
            flags_q[SEC_BIT_SINGLE] <= 1'b0;
         end
         if (double_ev) begin
            flags_q[SEC_BIT_DOUBLE] <= 1'b1;
         end else if (clr_double) begin
            flags_q[SEC_BIT_DOUBLE] <= 1'b0;
         end
      end
   end

   // Enables held in the control unit
   // Enables come out of reset cleared
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         enable_q <= SEC_RST_ENABLE;
      end else if (state_q == ST_REG_WR && req_q.addr == SEC_REG_ENABLE) begin
         enable_q <= HWDATA[1:0];
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         err_addr_q <= SEC_RST_ERRADR;
      end else if (single_ev || double_ev) begin
         err_addr_q <= req_q.addr;
      end
   end

   // Normal interrupt, level while flag and enable
   // NMI, level while flag and enable
   assign IRQ = flags_q[SEC_BIT_SINGLE] && enable_q[SEC_BIT_SINGLE];
   assign NMI = flags_q[SEC_BIT_DOUBLE] && enable_q[SEC_BIT_DOUBLE];

   property p_sflag;
      @(posedge CLK) disable iff (RST)
      single_ev |=> flags_q[SEC_BIT_SINGLE];
   endproperty
   a_single_flag_set: assert property (p_sflag)
      else $error("single error flag not set");

   a_double_flag_set: assert property (
      @(posedge CLK) disable iff (RST)
      double_ev |=> flags_q[SEC_BIT_DOUBLE] && !$past(flags_q[0]) ==
                    !flags_q[0])
      else $error("double error flag not set");

   a_single_addr_cap: assert property (
      @(posedge CLK) disable iff (RST)
      single_ev |=> err_addr_q == $past(req_q.addr))
      else $error("single error address not captured");

   a_double_addr_cap: assert property (
      @(posedge CLK) disable iff (RST)
      double_ev |=> err_addr_q == $past(req_q.addr))
      else $error("double error address not captured");

   a_irq_raise: assert property (
      @(posedge CLK) disable iff (RST)
      single_ev && enable_q[SEC_BIT_SINGLE] |=> IRQ)
      else $error("interrupt missing after single error");

   a_nmi_raise: assert property (
      @(posedge CLK) disable iff (RST)
      double_ev && enable_q[SEC_BIT_DOUBLE] |=> NMI)
      else $error("nmi missing after double error");

   sequence s_full_read;
      mem_en && !mem_we ##1 !HREADYOUT ##1 HREADYOUT;
   endsequence
   a_read_full_word: assert property (
      @(posedge CLK) disable iff (RST)
      accept && !HWRITE && win_hit |=> s_full_read)
      else $error("read did not fetch full word");

   a_narrow_rmw: assert property (
      @(posedge CLK) disable iff (RST)
      accept && HWRITE && win_hit && HSIZE != SEC_SIZE_WORD
      |=> (mem_en && !mem_we) ##1 (mem_en && mem_we))
      else $error("narrow write skipped read-modify-write");

   a_code_stored: assert property (
      @(posedge CLK) disable iff (RST)
      mem_en && mem_we ##2 mem_en && !mem_we && mem_addr == $past(mem_addr, 2)
      ##1 1'b1 |-> !par_bad && syn == '0)
      else $error("stored code fails immediate readback");

   a_w1c_clear: assert property (
      @(posedge CLK) disable iff (RST)
      clr_single && !single_ev |=> !flags_q[SEC_BIT_SINGLE])
      else $error("write one did not clear single flag");

   a_corrected_out: assert property (
      @(posedge CLK) disable iff (RST)
      state_q == ST_RD_CHECK && single_ev
      |=> HRDATA == ($past(mem_rdata[31:0]) ^ $past(sec_flip(syn))))
      else $error("corrected data not returned");

   c_single_read: cover property (
      @(posedge CLK) disable iff (RST) single_ev && state_q == ST_RD_CHECK);
   c_double_read: cover property (
      @(posedge CLK) disable iff (RST) double_ev);
   c_narrow_write: cover property (
      @(posedge CLK) disable iff (RST) state_q == ST_RMW_MERGE);
   c_alias_read: cover property (
      @(posedge CLK) disable iff (RST)
      accept && !HWRITE && HADDR[31:16] == SEC_WIN_ALT);

endmodule // sec_ctrl
`default_nettype wire

// [sec_ahb_master.sv]
// AHB-Lite master model standing in for the processor or a DMA channel.
// Assumes one slave whose ready output is fed back as HREADY.
`timescale 1ns/1ns
`default_nettype none

module sec_ahb_master
   import sec_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        HREADY,
   input  wire logic [31:0] HRDATA,
   output var  logic        HSEL,
   output var  logic [31:0] HADDR,
   output var  logic [1:0]  HTRANS,
   output var  logic        HWRITE,
   output var  logic [2:0]  HSIZE,
   output var  logic [31:0] HWDATA
);
   initial begin
      HSEL   = 1'b0;
      HADDR  = 32'h0000_0000;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HSIZE  = SEC_SIZE_WORD;
      HWDATA = 32'h0000_0000;
   end

   // One single transfer; entered just after a rising edge
   task automatic xfer(input  logic        wr,
                       input  logic [31:0] a,
                       input  logic [2:0]  sz,
                       input  logic [31:0] wd,
                       output logic [31:0] rd);
      HSEL   <= 1'b1;
      HADDR  <= a;
      HTRANS <= 2'h2;
      HWRITE <= wr;
      HSIZE  <= sz;
      // Read right after the edge, so ready is the value that edge sampled
      do @(posedge CLK); while (HREADY !== 1'b1);
      HTRANS <= 2'h0;
      // Read data phase: write lines carry no stale copy
      HWDATA <= wr ? wd : ~HWDATA;
      do @(posedge CLK); while (HREADY !== 1'b1);
      // Read data taken at the same edge that saw ready high
      rd = HRDATA;
   endtask
endmodule // sec_ahb_master
`default_nettype wire

// [sec_ctrl_tb.sv]
// Self-checking bench for the SRAM ECC wrapper over AHB-Lite.
// Assumes the master model above; errors cannot be injected at the ports,
// so error flags, capture and interrupts are only seen staying quiet.
`timescale 1ns/1ns
`default_nettype none

module sec_ctrl_tb
   import sec_pkg::*;
;
   logic        CLK = 1'b0;
   logic        RST = 1'b1;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic [31:0] hrdata;
   logic        hresp;
   logic        irq;
   logic        nmi;
   logic [31:0] rd;
   logic [31:0] expw;
   logic [31:0] lane;
   int          mismatches = 0;
   int          checks_done = 0;
   logic [15:0] offs [6] = '{16'h0000, 16'h0004, 16'h7FFC,
                             16'hBFFC, 16'hC000, 16'hCFFC};

   always #50 CLK = ~CLK;

   sec_ctrl i_dut (
      .CLK       (CLK),
      .RST       (RST),
      .HSEL      (hsel),
      .HADDR     (haddr),
      .HTRANS    (htrans),
      .HWRITE    (hwrite),
      .HSIZE     (hsize),
      .HWDATA    (hwdata),
      .HREADY    (hready),
      .HREADYOUT (hready),
      .HRDATA    (hrdata),
      .HRESP     (hresp),
      .IRQ       (irq),
      .NMI       (nmi)
   );

   sec_ahb_master i_mst (
      .CLK    (CLK),
      .HREADY (hready),
      .HRDATA (hrdata),
      .HSEL   (hsel),
      .HADDR  (haddr),
      .HTRANS (htrans),
      .HWRITE (hwrite),
      .HSIZE  (hsize),
      .HWDATA (hwdata)
   );

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t ns: data %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t ns: level %b, expected %b", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [2:0] sz,
                     input logic [31:0] d);
      i_mst.xfer(1'b1, a, sz, d, rd);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [2:0] sz,
                         input logic [31:0] exp);
      i_mst.xfer(1'b0, a, sz, 32'h0000_0000, rd);
      chk32(rd, exp);
      chk1(hresp, 1'b0);
   endtask

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Whole run is about sixty transfers of at most four cycles
   initial begin
      repeat (5000) @(posedge CLK);
      mismatches++;
      complete_run();
   end

   initial begin
      repeat (4) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      chk1(irq, 1'b0);
      chk1(nmi, 1'b0);
      rd_chk(SEC_REG_ENABLE, SEC_SIZE_WORD, 32'h0000_0000);
      rd_chk(SEC_REG_STATUS, SEC_SIZE_WORD, 32'h0000_0000);
      rd_chk(SEC_REG_ERRADR, SEC_SIZE_WORD, SEC_RST_ERRADR);
      // Word writes first, since unwritten words may flag errors
      for (int i = 0; i < 6; i++) begin
         expw = {16'hA5C3, offs[i]};
         wr({SEC_WIN_PRI, offs[i]}, SEC_SIZE_WORD, expw);
      end
      for (int i = 0; i < 6; i++) begin
         expw = {16'hA5C3, offs[i]};
         rd_chk({SEC_WIN_ALT, offs[i]}, SEC_SIZE_WORD, expw);
         wr({SEC_WIN_ALT, offs[i]}, SEC_SIZE_WORD, ~expw);
         rd_chk({SEC_WIN_PRI, offs[i]}, SEC_SIZE_WORD, ~expw);
      end
      // Byte lanes merged one at a time, other lanes carry ones
      expw = 32'h0000_0000;
      wr({SEC_WIN_PRI, 16'h0010}, SEC_SIZE_WORD, expw);
      for (int k = 0; k < 4; k++) begin
         lane = 32'(8'h11 * (k + 1)) << (8 * k);
         expw = (expw & ~(32'hFF << (8 * k))) | lane;
         lane = lane | ~(32'hFF << (8 * k));
         wr({SEC_WIN_PRI, 16'h0010 + 16'(k)}, SEC_SIZE_BYTE, lane);
         rd_chk({SEC_WIN_ALT, 16'h0013 - 16'(k)}, SEC_SIZE_BYTE, expw);
      end
      wr({SEC_WIN_PRI, 16'h0012}, SEC_SIZE_HALF, 32'h1234_FFFF);
      expw = {16'h1234, expw[15:0]};
      rd_chk({SEC_WIN_PRI, 16'h0010}, SEC_SIZE_WORD, expw);
      wr({SEC_WIN_ALT, 16'h0010}, SEC_SIZE_HALF, 32'hFFFF_BEEF);
      rd_chk({SEC_WIN_PRI, 16'h0012}, SEC_SIZE_HALF, 32'h1234_BEEF);
      // Control unit: enables hold two bits, flags clear by writing one
      wr(SEC_REG_ENABLE, SEC_SIZE_WORD, 32'hFFFF_FFFF);
      rd_chk(SEC_REG_ENABLE, SEC_SIZE_WORD, 32'h0000_0003);
      rd_chk({SEC_WIN_ALT, 16'hCFFC}, SEC_SIZE_WORD, ~32'hA5C3_CFFC);
      chk1(irq, 1'b0);
      chk1(nmi, 1'b0);
      wr(SEC_REG_STATUS, SEC_SIZE_WORD, 32'h0000_0003);
      rd_chk(SEC_REG_STATUS, SEC_SIZE_WORD, 32'h0000_0000);
      wr(SEC_REG_ERRADR, SEC_SIZE_WORD, 32'hFFFF_FFFF);
      rd_chk(SEC_REG_ERRADR, SEC_SIZE_WORD, SEC_RST_ERRADR);
      wr(SEC_REG_ENABLE, SEC_SIZE_WORD, 32'h0000_0000);
      rd_chk(SEC_REG_ENABLE, SEC_SIZE_WORD, 32'h0000_0000);
      // Past the shared region nothing is stored or aliased
      wr({SEC_WIN_PRI, SEC_WIN_LIMIT}, SEC_SIZE_WORD, 32'hDEAD_BEEF);
      expw = 32'h0000_0000;
      rd_chk({SEC_WIN_PRI, SEC_WIN_LIMIT}, SEC_SIZE_WORD, expw);
      rd_chk({SEC_WIN_ALT, 16'h0000}, SEC_SIZE_WORD, ~32'hA5C3_0000);
      rd_chk({SEC_WIN_PRI, 16'hC000}, SEC_SIZE_WORD, ~32'hA5C3_C000);
      // Second reset: control unit clears, the array keeps its words
      wr(SEC_REG_ENABLE, SEC_SIZE_WORD, 32'h0000_0003);
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      chk1(irq, 1'b0);
      rd_chk(SEC_REG_ENABLE, SEC_SIZE_WORD, 32'h0000_0000);
      rd_chk({SEC_WIN_ALT, 16'h0010}, SEC_SIZE_WORD, 32'h1234_BEEF);
      complete_run();
   end
endmodule // sec_ctrl_tb
`default_nettype wire
